// file: logic/atm_sequencer.sv
// Mode sequencer of the auto transfer controller, with its registers
// Function
// - Sixteen modes chosen by control reg zero
// - Modes 0-D standard, E and F burst
// - Standard: one operation, count down, release bus
// - Standard: count zero raises interrupt, stops
// - Finished sequence ignores further trigger events
// - Burst: count down per byte, interrupt at zero
// - Stop enable halts burst on interrupt flag
// - Halt keeps count and both pointers
// - Next activation resumes halted burst
// - I/O address is page 03F plus pointer 1 low
// - Mode 0: memory to I/O, no increment
// - Mode 1: I/O to memory, no increment
// - Mode 2: memory to I/O, pointer 0 increments
// - Mode 3: I/O to memory, pointer 0 increments
// - Mode 4: two bytes to even, odd I/O
// - Mode 5: even, odd I/O into memory
// - Mode 6: I/O in, then memory out, increments
// - Mode 6 runs up to 255 activations
// - Each byte is a load then a store
// - Request bus, transfer only after grant
// - Refuse activation while count is zero
// - Fixed pointer bit stops pointer 0 increments
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
module atm_sequencer
   import atm_pkg::*;
(
   input wire logic core_clk, // System clock, 20 MHz
   input wire logic reset, // Synchronous reset, high
   input wire logic clk_en, // Freezes state when low
   input wire logic [15:0] avs_address, // Register byte address
   input wire logic avs_read, // Register read
   input wire logic avs_write, // Register write
   input wire logic [31:0] avs_writedata, // Register write data
   input wire logic [3:0] avs_byteenable, // Register byte lanes
   output logic [31:0] avs_readdata, // Register read data
   output logic avs_waitrequest, // Register stall
   input wire logic trigger_event, // Selected activation factor pulse
   input wire logic ext_int0_request_flag, // External interrupt 0 flag
   output logic bus_request, // Ask the core for the bus
   input wire logic bus_grant, // Core has released the bus
   output logic [17:0] mem_addr, // Internal bus address
   output logic mem_rd, // Load cycle strobe
   output logic mem_wr, // Store cycle strobe
   output logic [7:0] mem_wdata, // Store data
   input wire logic [7:0] mem_rdata, // Load data
   input wire logic mem_ready, // Bus cycle finishes this edge
   output logic transfer_done_irq // Completion pulse
);

   // Every check below runs on the system clock and sleeps in reset
   default clocking chk_cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [3:0] mode; // Selected mode
   logic fixed_bit; // Pointer 0 frozen
   logic stop_en; // Burst stop enable
   logic [7:0] count; // Transfer count
   logic [17:0] p0; // Pointer 0
   logic [17:0] p1; // Pointer 1
   logic sw_start; // Software activation
   logic cnt_dec; // Count down strobe
   logic p0_inc; // Pointer 0 step strobe
   logic p1_inc; // Pointer 1 step strobe
   atm_seq_state_t s_reg; // Registered state
   atm_seq_state_t s_next; // Next state

   atm_regs u_regs (
      .core_clk(core_clk),
      .reset(reset),
      .clk_en(clk_en),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .hw_cnt_dec(cnt_dec),
      .hw_p0_inc(p0_inc),
      .hw_p1_inc(p1_inc),
      .st_busy(s_reg.phase != ST_IDLE),
      .st_halted(s_reg.halted),
      .mode(mode),
      .fixed_pointer_bit(fixed_bit),
      .burst_stop_enable(stop_en),
      .count(count),
      .p0(p0),
      .p1(p1),
      .sw_start(sw_start)
   );

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   logic burst; // Burst mode selected
   logic two_byte; // Two bytes per activation
   logic p0_steps; // Mode moves pointer 0
   logic last_byte; // Current byte steps the count: last byte of a standard activation, or any burst byte
   logic start; // Activation event
   logic [17:0] p0_after; // Pointer 0 after this byte
   logic [17:0] p1_after; // Pointer 1 after this byte

   assign burst = (mode >= MODE_BURST_E);
   assign two_byte = (mode == 4'h4) || (mode == 4'h5) || (mode == 4'h6);
   assign p0_steps = ((mode >= 4'h2) && (mode <= 4'h6)) || burst;
   assign last_byte = burst || !two_byte || s_reg.step;
   assign start = trigger_event | sw_start;
   assign p0_after = p0_inc ? p0 + 18'h00001 : p0;
   assign p1_after = p1_inc ? p1 + 18'h00001 : p1;

   // Source side is I/O for modes 1, 3, 5 and the first byte of mode 6
   function automatic logic src_io(input logic [3:0] m, input logic st);
      src_io = (m == 4'h1) || (m == 4'h3) || (m == 4'h5) ||
         ((m == 4'h6) && !st);
   endfunction : src_io

   // I/O page address; the second byte of modes 4/5 takes the odd one
   function automatic logic [17:0] io_addr(input logic [17:0] q1,
      input logic [3:0] m, input logic st);
      logic [7:0] lo;
      lo = q1[7:0];
      if (st && (m == 4'h4 || m == 4'h5)) begin
         lo = q1[7:0] + 8'h01;
      end
      io_addr = {IO_PAGE, lo};
   endfunction : io_addr

   // Burst copies pointer 0 to the full pointer 1 address
   function automatic logic [17:0] src_addr(input logic [17:0] q0,
      input logic [17:0] q1, input logic [3:0] m, input logic st);
      src_addr = src_io(m, st) ? io_addr(q1, m, st) : q0;
   endfunction : src_addr

   function automatic logic [17:0] dst_addr(input logic [17:0] q0,
      input logic [17:0] q1, input logic [3:0] m, input logic st);
      if (m >= MODE_BURST_E) begin
         dst_addr = q1;
      end else if (src_io(m, st)) begin
         dst_addr = q0;
      end else begin
         dst_addr = io_addr(q1, m, st);
      end
   endfunction : dst_addr

   // ----------------------------------------------------------------
   // Hardware update strobes, taken when a store finishes
   // ----------------------------------------------------------------
   always_comb begin
      cnt_dec = 1'b0;
      p0_inc = 1'b0;
      p1_inc = 1'b0;
      if (s_reg.phase == ST_STORE && mem_ready && clk_en) begin
         p0_inc = p0_steps && !fixed_bit;
         p1_inc = burst;
         cnt_dec = last_byte;
      end
   end

   // ----------------------------------------------------------------
   // Sequencer next state
   // ----------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.irq = 1'b0;
      unique case (s_reg.phase)
         ST_IDLE: begin
            // Zero count refuses activation, so a finished run stays put
            if (start && count != 8'h00) begin
               s_next.phase = ST_REQ;
               s_next.halted = 1'b0;
               s_next.step = 1'b0;
            end
         end
         ST_REQ: begin
            // Bus is only touched once the core grants it
            if (bus_grant) begin
               s_next.phase = ST_LOAD;
               s_next.rd = 1'b1;
               s_next.addr = src_addr(p0, p1, mode, s_reg.step);
            end
         end
         ST_LOAD: begin
            if (mem_ready) begin
               s_next.phase = ST_STORE;
               s_next.rd = 1'b0;
               s_next.wr = 1'b1;
               s_next.wdata = mem_rdata;
               s_next.addr = dst_addr(p0, p1, mode, s_reg.step);
            end
         end
         ST_STORE: begin
            if (mem_ready) begin
               s_next.wr = 1'b0;
               if (last_byte && count == 8'h01) begin
                  s_next.irq = 1'b1;
                  s_next.phase = ST_IDLE;
               end else if (burst && stop_en && ext_int0_request_flag) begin
                  // Pointers and count step for this byte on this same edge
                  s_next.halted = 1'b1;
                  s_next.phase = ST_IDLE;
               end else if (burst || !last_byte) begin
                  s_next.step = !burst;
                  s_next.phase = ST_LOAD;
                  s_next.rd = 1'b1;
                  s_next.addr = src_addr(p0_after, p1_after, mode,
                     !burst);
               end else begin
                  s_next.phase = ST_IDLE;
               end
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         s_reg <= '0;
         s_reg.phase <= ST_IDLE;
      end else if (clk_en) begin
         s_reg <= s_next;
      end
   end

   // Request stands from activation until the bus is handed back
   assign bus_request = (s_reg.phase != ST_IDLE);
   assign mem_addr = s_reg.addr;
   assign mem_rd = s_reg.rd;
   assign mem_wr = s_reg.wr;
   assign mem_wdata = s_reg.wdata;
   assign transfer_done_irq = s_reg.irq;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   bus_owned_a: assert property (
      (mem_rd || mem_wr) |-> bus_request)
      else $error("bus cycle without bus request");

   io_page_a: assert property (
      (mem_rd && src_io(mode, s_reg.step) && !burst)
      |-> mem_addr[17:8] == IO_PAGE)
      else $error("I/O access outside I/O page");

   zero_refuse_a: assert property (
      (clk_en && s_reg.phase == ST_IDLE && count == 8'h00)
      |=> s_reg.phase == ST_IDLE)
      else $error("activation taken with zero count");

   done_count_a: assert property (
      transfer_done_irq |-> (count == 8'h00 && !bus_request))
      else $error("completion without zero count");

   load_store_a: assert property (
      (clk_en && mem_rd && mem_ready)
      |=> (mem_wr && !mem_rd && mem_wdata == $past(mem_rdata)))
      else $error("load not followed by store");

   fixed_ptr_a: assert property (
      (fixed_bit || mode < 4'h2 || (mode > 4'h6 && !burst)) |-> !p0_inc)
      else $error("pointer 0 moved while fixed");

   burst_halt_a: assert property (
      (clk_en && mem_wr && mem_ready && burst && stop_en &&
       ext_int0_request_flag && count != 8'h01)
      |=> (s_reg.halted && !bus_request))
      else $error("burst not halted by interrupt flag");

   word_odd_a: assert property (
      (clk_en && mode == 4'h4 && mem_wr && mem_ready && !s_reg.step)
      |=> ##[1:16] (mem_wr && mem_addr == {IO_PAGE, p1[7:0] + 8'h01}))
      else $error("second word byte not at odd address");

endmodule : atm_sequencer

// file: logic/atm_pkg.sv
// Package: constants and types of the auto transfer mode sequencer
package atm_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [13:0] IDX_CTRL0 = 14'h3FD0; // Transfer control reg zero
   localparam logic [13:0] IDX_CTRL1 = 14'h3FD1; // Transfer control reg one
   localparam logic [13:0] IDX_COUNT = 14'h3FD2; // Transfer count reg
   localparam logic [13:0] IDX_P0_LOW = 14'h3FD3; // Pointer 0 low byte
   localparam logic [13:0] IDX_P0_MID = 14'h3FD4; // Pointer 0 middle byte
   localparam logic [13:0] IDX_P0_HIGH = 14'h3FD5; // Pointer 0 upper 2 bits
   localparam logic [13:0] IDX_P1_LOW = 14'h3FD6; // Pointer 1 low byte
   localparam logic [13:0] IDX_P1_MID = 14'h3FD7; // Pointer 1 middle byte
   localparam logic [13:0] IDX_P1_HIGH = 14'h3FD8; // Pointer 1 upper 2 bits

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL0_MODE_LSB = 0; // Mode field, 4 bits
   localparam int CTRL0_FIXED_BIT = 4; // Fixed pointer bit
   localparam int CTRL1_STOP_BIT = 0; // Burst stop enable
   localparam int CTRL1_START_BIT = 1; // Software activation, reads zero
   localparam int CTRL1_BUSY_BIT = 6; // Sequence running, read only
   localparam int CTRL1_HALT_BIT = 7; // Burst halted, read only

   // ----------------------------------------------------------------
   // Reset values and fixed codes
   // ----------------------------------------------------------------
   localparam logic [4:0] CTRL0_RESET = 5'h00; // Mode 0, fixed bit clear
   localparam logic CTRL1_RESET = 1'b0; // Burst stop disabled
   localparam logic [7:0] COUNT_RESET = 8'h00; // Count zero, no activation
   localparam logic [17:0] PTR_RESET = 18'h00000; // Pointers cleared
   localparam logic [9:0] IO_PAGE = 10'h03F; // Upper bits of I/O space
   localparam logic [3:0] MODE_BURST_E = 4'hE; // First burst mode

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_REQ,
      ST_LOAD,
      ST_STORE
   } atm_phase_t;

   typedef struct packed {
      logic [4:0] ctrl0; // Mode and fixed bit
      logic stop_en; // Burst stop enable
      logic [7:0] count; // Transfer count
      logic [17:0] p0; // Pointer 0
      logic [17:0] p1; // Pointer 1
      logic ack; // Bus answer this cycle
      logic [31:0] rdata; // Registered read data
      logic start; // Software activation pulse
   } atm_regs_state_t;

   typedef struct packed {
      atm_phase_t phase; // Sequencer phase
      logic step; // Byte index within an activation
      logic halted; // Burst stopped by external interrupt 0
      logic irq; // Completion pulse
      logic [17:0] addr; // Bus address
      logic rd; // Load strobe
      logic wr; // Store strobe
      logic [7:0] wdata; // Store data
   } atm_seq_state_t;

endpackage : atm_pkg

// file: logic/atm_regs.sv
// Avalon-MM register file of the auto transfer mode sequencer
`timescale 1ns/100ps
module atm_regs
   import atm_pkg::*;
(
   input wire logic core_clk, // System clock
   input wire logic reset, // Synchronous reset, high
   input wire logic clk_en, // Freezes state when low
   input wire logic [15:0] avs_address, // Byte address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Byte lanes
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall
   input wire logic hw_cnt_dec, // Count down by one
   input wire logic hw_p0_inc, // Pointer 0 up by one
   input wire logic hw_p1_inc, // Pointer 1 up by one
   input wire logic st_busy, // Sequence running
   input wire logic st_halted, // Burst halted
   output logic [3:0] mode, // Mode field
   output logic fixed_pointer_bit, // Pointer 0 frozen
   output logic burst_stop_enable, // Burst stop enable
   output logic [7:0] count, // Transfer count
   output logic [17:0] p0, // Pointer 0
   output logic [17:0] p1, // Pointer 1
   output logic sw_start // Software activation pulse
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   atm_regs_state_t s_reg; // Registered state
   atm_regs_state_t s_next; // Next state
   logic [13:0] idx; // Word index
   logic req; // Access pending
   logic wr_ok; // Write takes effect now
   logic [7:0] wb; // Low write byte

   assign idx = avs_address[15:2];
   assign req = avs_read | avs_write;
   assign wr_ok = avs_write & s_reg.ack & avs_byteenable[0]; // At stall low
   assign wb = avs_writedata[7:0];

   // Every access answers on the cycle after it is raised; a low clock
   // enable keeps the stall up so a frozen write is never lost
   assign avs_waitrequest = req & ~(s_reg.ack & clk_en);
   assign avs_readdata = s_reg.rdata;
   assign mode = s_reg.ctrl0[CTRL0_MODE_LSB +: 4];
   assign fixed_pointer_bit = s_reg.ctrl0[CTRL0_FIXED_BIT];
   assign burst_stop_enable = s_reg.stop_en;
   assign count = s_reg.count;
   assign p0 = s_reg.p0;
   assign p1 = s_reg.p1;
   assign sw_start = s_reg.start;

   // ----------------------------------------------------------------
   // Next state: hardware updates first, software writes override
   // ----------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.start = 1'b0;
      s_next.ack = req & ~s_reg.ack;
      // Hardware side; a software write in the same cycle wins
      if (hw_cnt_dec) begin
         s_next.count = s_reg.count - 8'h01;
      end
      if (hw_p0_inc) begin
         s_next.p0 = s_reg.p0 + 18'h00001;
      end
      if (hw_p1_inc) begin
         s_next.p1 = s_reg.p1 + 18'h00001;
      end
      // Write decode; unmapped writes are dropped
      if (wr_ok) begin
         unique case (idx)
            IDX_CTRL0: s_next.ctrl0 = wb[4:0];
            IDX_CTRL1: begin
               s_next.stop_en = wb[CTRL1_STOP_BIT];
               s_next.start = wb[CTRL1_START_BIT];
            end
            IDX_COUNT: s_next.count = wb;
            IDX_P0_LOW: s_next.p0[7:0] = wb;
            IDX_P0_MID: s_next.p0[15:8] = wb;
            IDX_P0_HIGH: s_next.p0[17:16] = wb[1:0];
            IDX_P1_LOW: s_next.p1[7:0] = wb;
            IDX_P1_MID: s_next.p1[15:8] = wb;
            IDX_P1_HIGH: s_next.p1[17:16] = wb[1:0];
            default: s_next.start = 1'b0; // Unmapped
         endcase
      end
      // Read decode; unmapped reads answer zero
      s_next.rdata = 32'h00000000;
      if (avs_read & ~s_reg.ack) begin
         unique case (idx)
            IDX_CTRL0: s_next.rdata[4:0] = s_reg.ctrl0;
            IDX_CTRL1: begin
               s_next.rdata[CTRL1_STOP_BIT] = s_reg.stop_en;
               s_next.rdata[CTRL1_BUSY_BIT] = st_busy;
               s_next.rdata[CTRL1_HALT_BIT] = st_halted;
            end
            IDX_COUNT: s_next.rdata[7:0] = s_reg.count;
            IDX_P0_LOW: s_next.rdata[7:0] = s_reg.p0[7:0];
            IDX_P0_MID: s_next.rdata[7:0] = s_reg.p0[15:8];
            IDX_P0_HIGH: s_next.rdata[1:0] = s_reg.p0[17:16];
            IDX_P1_LOW: s_next.rdata[7:0] = s_reg.p1[7:0];
            IDX_P1_MID: s_next.rdata[7:0] = s_reg.p1[15:8];
            IDX_P1_HIGH: s_next.rdata[1:0] = s_reg.p1[17:16];
            default: s_next.rdata = 32'h00000000; // Unmapped
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         s_reg <= '0;
         s_reg.ctrl0 <= CTRL0_RESET;
         s_reg.stop_en <= CTRL1_RESET;
         s_reg.count <= COUNT_RESET;
         s_reg.p0 <= PTR_RESET;
         s_reg.p1 <= PTR_RESET;
      end else if (clk_en) begin
         s_reg <= s_next;
      end
   end

endmodule : atm_regs

// file: dv/atm_core_model.sv
// Core arbitration and memory model beside the sequencer
`timescale 1ns/100ps
module atm_core_model (
   input wire logic core_clk, // System clock
   input wire logic reset, // Synchronous reset, high
   input wire logic bus_request, // Sequencer asks for bus
   output logic bus_grant, // Bus handed over
   input wire logic [17:0] mem_addr, // Bus address
   input wire logic mem_rd, // Load strobe
   input wire logic mem_wr, // Store strobe
   output logic [7:0] mem_rdata, // Load data
   output logic mem_ready // Cycle ends at next edge
);
   logic [2:0] gcnt; // Cycles since request
   logic [1:0] wcnt; // Wait states spent
   logic slow; // Alternates prompt and slow grant
   logic [7:0] pat; // Memory byte at mem_addr
   // ----------------------------------------------------------------
   // Memory is a fixed function of the address
   // ----------------------------------------------------------------
   assign pat = mem_addr[7:0] ^ mem_addr[15:8] ^ {6'h00, mem_addr[17:16]}
      ^ 8'h5A;
   // Inverted outside a ready cycle, so stale data never looks good
   assign mem_rdata = mem_ready ? pat : ~pat;
   // Grant after one or four cycles; odd addresses add two waits
   always_ff @(posedge core_clk) begin
      if (reset) begin
         bus_grant <= 1'b0;
         gcnt <= 3'h0;
         slow <= 1'b0;
         wcnt <= 2'h0;
         mem_ready <= 1'b0;
      end else begin
         if (!bus_request) begin
            bus_grant <= 1'b0;
            gcnt <= 3'h0;
         end else if (!bus_grant) begin
            gcnt <= gcnt + 3'h1;
            if (gcnt == (slow ? 3'h3 : 3'h0)) begin
               bus_grant <= 1'b1;
               slow <= !slow;
            end
         end
         if (mem_ready) begin
            mem_ready <= 1'b0;
            wcnt <= 2'h0;
         end else if ((mem_rd | mem_wr) && wcnt == {mem_addr[0], 1'b0}) begin
            mem_ready <= 1'b1;
         end else if (mem_rd | mem_wr) begin
            wcnt <= wcnt + 2'h1;
         end
      end
   end
endmodule : atm_core_model

// file: dv/atm_sequencer_bench.sv
// Self-checking bench of the auto transfer mode sequencer
`timescale 1ns/100ps
module atm_sequencer_bench import atm_pkg::*;;
   logic core_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, trigger_event = 1'b0;
   logic avs_read = 1'b0, avs_write = 1'b0, ext_int0_request_flag = 1'b0;
   logic [15:0] avs_address = 16'h0000;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, r;
   logic avs_waitrequest, bus_request, bus_grant, mem_rd, mem_wr;
   logic mem_ready, transfer_done_irq;
   logic [17:0] mem_addr, p0, p1;
   logic [7:0] mem_wdata, mem_rdata, q;
   logic [25:0] exp_q[$]; // Expected stores, address and data
   int fail_count = 0, n_tests = 0, irq_n = 0, i, m;
   logic [31:0] seed = 32'h7ECC3ED0;
   always #25 core_clk = ~core_clk;
   atm_sequencer dut_u (.core_clk, .reset, .clk_en, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF),
      .avs_readdata, .avs_waitrequest, .trigger_event,
      .ext_int0_request_flag, .bus_request, .bus_grant, .mem_addr, .mem_rd,
      .mem_wr, .mem_wdata, .mem_rdata, .mem_ready, .transfer_done_irq);
   atm_core_model far_u (.core_clk, .reset, .bus_request, .bus_grant,
      .mem_addr, .mem_rd, .mem_wr, .mem_rdata, .mem_ready);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] pat(input logic [17:0] a);
      return a[7:0] ^ a[15:8] ^ {6'h00, a[17:16]} ^ 8'h5A;
   endfunction : pat
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic chk(input logic [25:0] seen, input logic [25:0] want);
      n_tests++;
      if (seen !== want) begin
         fail_count++;
         $display("unexpected at %0t: seen %h want %h", $time, seen, want);
      end
   endtask : chk
   task wrap_up;
      if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   // Bounded wait ran out: counts as a mismatch
   task tmo(input int n);
      if (n >= 300) begin
         fail_count++;
         wrap_up;
      end
   endtask : tmo
   // One Avalon access; read data taken at the completion edge
   task bus(input logic [13:0] idx, input logic w, input logic [7:0] d);
      @(posedge core_clk);
      avs_address <= {idx, 2'b00};
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h0, d};
      for (i = 0; i < 300; i++) begin
         @(posedge core_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      tmo(i);
      q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task rd_chk(input logic [13:0] idx, input logic [7:0] want);
      bus(idx, 1'b0, 8'h00);
      chk(q, want);
   endtask : rd_chk
   task setup(input logic [4:0] c0, input logic st, input logic [7:0] n);
      bus(IDX_CTRL0, 1'b1, {3'h0, c0});
      bus(IDX_CTRL1, 1'b1, {7'h0, st});
      bus(IDX_COUNT, 1'b1, n);
      for (int k = 0; k < 3; k++) begin
         bus(IDX_P0_LOW + 14'(k), 1'b1, 8'(p0 >> 8 * k));
         bus(IDX_P1_LOW + 14'(k), 1'b1, 8'(p1 >> 8 * k));
      end
   endtask : setup
   // Trigger pulse or software start, then wait for the bus round trip
   task act(input logic on, input logic halt, input logic sw = 1'b0);
      logic seen;
      seen = 1'b0;
      if (sw) begin
         bus(IDX_CTRL1, 1'b1, 8'h03); // Stop enable set, start set
      end else begin
         @(posedge core_clk);
         trigger_event <= 1'b1;
         @(posedge core_clk);
         trigger_event <= 1'b0;
      end
      for (i = 0; i < 300 && !(i == 12 && !on); i++) begin
         @(posedge core_clk);
         if (halt && mem_wr === 1'b1 && mem_ready === 1'b1)
            ext_int0_request_flag <= 1'b1;
         if (bus_request === 1'b1) seen = 1'b1;
         if (seen && bus_request === 1'b0) break;
      end
      tmo(i);
      chk(seen, on);
   endtask : act
   // Expected stores of one standard activation; steps pointer 0
   task note(input logic [3:0] md, input logic [17:0] inc);
      logic [17:0] a, b;
      a = {IO_PAGE, p1[7:0]};
      b = {IO_PAGE, p1[7:1], 1'b1};
      case (md)
         4'h1, 4'h3: exp_q.push_back({p0, pat(a)});
         4'h4: begin
            exp_q.push_back({a, pat(p0)});
            p0 += inc;
            exp_q.push_back({b, pat(p0)});
         end
         4'h5: begin
            exp_q.push_back({p0, pat(a)});
            p0 += inc;
            exp_q.push_back({p0, pat(b)});
         end
         4'h6: begin
            exp_q.push_back({p0, pat(a)});
            p0 += inc;
            exp_q.push_back({a, pat(p0)});
         end
         default: exp_q.push_back({a, pat(p0)});
      endcase
      if (md >= 4'h2) p0 += inc;
   endtask : note
   // ----------------------------------------------------------------
   // Watcher: every finished store must match the oldest note
   // ----------------------------------------------------------------
   always @(posedge core_clk) begin
      if (!reset) begin
         if (transfer_done_irq === 1'b1) irq_n++;
         if ((mem_rd | mem_wr) === 1'b1) chk(bus_grant, 1'b1);
         if ((mem_wr & mem_ready) === 1'b1)
            chk({mem_addr, mem_wdata}, exp_q.size() ? exp_q.pop_front() :
               ~{mem_addr, mem_wdata});
      end
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (5) @(posedge core_clk);
      reset <= 1'b0;
      rd_chk(IDX_COUNT, COUNT_RESET);
      rd_chk(14'h0000, 8'h00);
      act(1'b0, 1'b0);
      // Modes 0 to 6, then mode 2 with pointer 0 frozen
      for (m = 0; m < 8; m++) begin
         r = rnd();
         p0 = (m == 6) ? 18'h3FFFF : r[17:0];
         p1 = {r[31:22], r[25:19], 1'b0};
         setup({m == 7, (m == 7) ? 4'h2 : 4'(m)}, 1'b0, 8'h02);
         repeat (2) begin
            note((m == 7) ? 4'h2 : 4'(m), {17'h0, m != 7});
            act(1'b1, 1'b0);
         end
         act(1'b0, 1'b0);
         rd_chk(IDX_P0_LOW, p0[7:0]);
         rd_chk(IDX_P0_HIGH, {6'h0, p0[17:16]});
         rd_chk(IDX_COUNT, 8'h00);
      end
      // Burst of four halted by external interrupt 0, then resumed
      r = rnd();
      p0 = r[17:0];
      p1 = r[31:14];
      setup({1'b0, MODE_BURST_E}, 1'b1, 8'h04);
      for (int k = 0; k < 4; k++)
         exp_q.push_back({p1 + 18'(k), pat(p0 + 18'(k))});
      act(1'b1, 1'b1);
      rd_chk(IDX_COUNT, 8'h02);
      p0 += 18'h2;
      rd_chk(IDX_P0_LOW, p0[7:0]);
      rd_chk(IDX_CTRL1, 8'((1 << CTRL1_HALT_BIT) | (1 << CTRL1_STOP_BIT)));
      @(posedge core_clk);
      ext_int0_request_flag <= 1'b0;
      act(1'b1, 1'b0, 1'b1);
      @(posedge core_clk);
      chk(irq_n, 9);
      chk(exp_q.size(), 0);
      wrap_up;
   end
endmodule : atm_sequencer_bench
